// ==== inc/fpl_pkg.sv ====
package fpl_pkg;
  // register indices on the plain port
  localparam logic [3:0] ADDR_PROP = 4'h0;
  localparam logic [3:0] ADDR_STAT = 4'h1;
  localparam logic [3:0] ADDR_RESP = 4'h2;
  localparam logic [3:0] ADDR_LATCH = 4'h3;
  // bit positions shared by enable, status, latch
  localparam int BIT_OV = 1;
  localparam int BIT_UV = 2;
  localparam int BIT_OC = 3;
  localparam int BIT_OT = 4;
  localparam int BIT_TR = 5;
  localparam int BIT_TW = 7;
  // response select bits
  localparam int RESP_UV_CRIT = 0;
  localparam int RESP_OT_CRIT = 1;
  localparam int RESP_OV_EMERG = 2;
  // reset values and writable-bit mask
  localparam logic [7:0] PROP_RST = 8'h3f;
  localparam logic [7:0] PROP_MASK = 8'h3f;
  localparam logic [7:0] RESP_RST = 8'h00;
  localparam logic [7:0] LATCH_RST = 8'h00;
  // hiccup interval
  localparam int RETRY_MS = 130;
  localparam int CLK_MHZ = 250;
  localparam int RETRY_CYC = RETRY_MS * CLK_MHZ * 1000;
  // line pattern length in sync periods
  localparam logic [2:0] ENC_LAST = 3'h4;
  // turn-off kinds
  typedef enum logic [1:0] {
    OFF_NONE, OFF_SEQ, OFF_CRIT, OFF_EMERG
  } fpl_off_t;
  // detector levels, same clock domain
  typedef struct packed {
    logic tempWarn;
    logic tracking;
    logic overTemp;
    logic overCurrent;
    logic underVolt;
    logic overVolt;
  } fpl_faults_t;
  // register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } fpl_reg_req_t;
endpackage

// ==== verilog/fpl_pin_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
// three-stage sampler with agreement filter
module fpl_pin_sync
  import fpl_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic pinIn,
  output logic level,
  output logic rise,
  output logic fall
);
  logic s1_q; // first stage, read by s2 only
  logic s2_q;
  logic s3_q;
  logic lvl_q; // accepted level
  // shift chain
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
    end else begin
      s1_q <= pinIn;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  // accept once stages two and three agree
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lvl_q <= 1'b1;
    end else if (s2_q == s3_q) begin
      lvl_q <= s3_q;
    end
  end
  assign level = lvl_q;
  assign rise = (s2_q == s3_q) && s3_q && !lvl_q;
  assign fall = (s2_q == s3_q) && !s3_q && lvl_q;
endmodule
`default_nettype wire

// ==== verilog/fpl_line_decoder.sv ====
`timescale 1ns/1ps
`default_nettype none
// classifies a peer pattern on the fault line
module fpl_line_decoder
  import fpl_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic syncRise,
  input wire logic lineLvl,
  output logic valid,
  output fpl_off_t kind
);
  logic [2:0] cnt_q; // samples taken plus one, 0 idle
  logic [3:0] smp_q; // line samples
  logic valid_q;
  fpl_off_t kind_q;
  // sample on sync rising edges, one pattern at a time
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_q <= 3'h0;
      smp_q <= 4'h0;
    end else if (cnt_q == ENC_LAST + 3'h1) begin
      cnt_q <= 3'h0; // decision taken, idle again
    end else if (start && cnt_q == 3'h0) begin
      cnt_q <= 3'h1; // falls inside a pattern belong to it
      smp_q <= 4'h0;
    end else if (cnt_q != 3'h0 && syncRise) begin
      smp_q <= {lineLvl, smp_q[3:1]};
      cnt_q <= cnt_q + 3'h1;
    end
  end
  // decide after the fourth sample; the first one is the start step, always low
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      valid_q <= 1'b0;
      kind_q <= OFF_NONE;
    end else begin
      valid_q <= 1'b0;
      if (cnt_q == ENC_LAST + 3'h1) begin
        valid_q <= 1'b1;
        if (!smp_q[1]) kind_q <= OFF_SEQ;
        else if (smp_q[3]) kind_q <= OFF_EMERG;
        else kind_q <= OFF_CRIT;
      end
    end
  end
  assign valid = valid_q;
  assign kind = kind_q;
endmodule
`default_nettype wire

// ==== verilog/fpl_fault_prop.sv ====
`timescale 1ns/1ps
`default_nettype none
module fpl_fault_prop
  import fpl_pkg::*;
#(
  parameter int RETRY_CYCLES = RETRY_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire fpl_reg_req_t regReq,
  output logic [7:0] regRdata,
  input wire fpl_faults_t faultIn,
  input wire logic vinPresent,
  input wire logic rampPhase,
  input wire logic steadyState,
  input wire logic aboveBias,
  input wire logic syncClockLine,
  input wire logic okLineIn,
  output logic okLineOut,
  output logic okLineOe,
  output logic convEnable,
  output fpl_off_t offType,
  output logic lowSideOn,
  output logic restartPulse
);
  // control states
  typedef enum logic [1:0] {
    ST_RUN, ST_OFF, ST_PEER, ST_HOLD
  } fpl_state_t;
  fpl_state_t state_q; // turn-off state
  logic [7:0] prop_q; // propagation enables
  logic [7:0] resp_q; // response choices
  logic [7:0] latch_q; // latching per fault
  logic [7:0] stat_q; // sticky status
  logic [7:0] rdata_q; // read data
  logic [31:0] retry_q; // hiccup counter
  logic pending_q; // send request
  logic lineLow_q; // pulling line low
  logic [2:0] step_q; // pattern step
  fpl_off_t drvType_q; // kind being sent
  fpl_off_t offType_q; // current kind
  logic lowSide_q; // low side held on
  logic restart_q; // restart pulse
  logic [7:0] faultSrc_q; // own fault bit
  logic syncLvl; // filtered sync line
  logic syncRise;
  logic syncFall;
  logic lineLvl; // filtered fault line
  logic lineRise;
  logic lineFall;
  logic decValid;
  fpl_off_t decKind;
  logic sendActive; // own pattern in flight
  logic [7:0] gated; // faults qualified by phase
  logic [7:0] selBit; // chosen fault, one-hot
  fpl_off_t selType; // kind for chosen fault
  logic selProp; // chosen fault propagates
  logic anyFault;
  logic releaseReq; // leave off state
  // sync line sampler
  fpl_pin_sync syncIn (
    .clk(clk),
    .sys_rst(sys_rst),
    .pinIn(syncClockLine),
    .level(syncLvl),
    .rise(syncRise),
    .fall(syncFall)
  );
  // fault line sampler
  fpl_pin_sync lineIn (
    .clk(clk),
    .sys_rst(sys_rst),
    .pinIn(okLineIn),
    .level(lineLvl),
    .rise(lineRise),
    .fall(lineFall)
  );
  // peer pattern classifier
  fpl_line_decoder dec (
    .clk(clk),
    .sys_rst(sys_rst),
    .start(lineFall && !sendActive),
    .syncRise(syncRise),
    .lineLvl(lineLvl),
    .valid(decValid),
    .kind(decKind)
  );
  // low level wanted at a pattern step
  function automatic logic patLow(input logic [2:0] st, input fpl_off_t k);
    if (st == 3'h1) patLow = (k == OFF_SEQ);
    else if (st == 3'h3) patLow = (k != OFF_EMERG);
    else patLow = 1'b1;
  endfunction
  assign sendActive = lineLow_q || (step_q != 3'h0);
  // qualify detectors by when each is active
  always_comb begin
    gated = 8'h00;
    gated[BIT_TW] = faultIn.tempWarn && vinPresent;
    gated[BIT_OT] = faultIn.overTemp && vinPresent;
    gated[BIT_TR] = faultIn.tracking && rampPhase;
    gated[BIT_UV] = faultIn.underVolt && steadyState;
    gated[BIT_OC] = faultIn.overCurrent && aboveBias;
    gated[BIT_OV] = faultIn.overVolt && aboveBias;
  end
  // pick worst fault and its kind
  always_comb begin
    selBit = 8'h00;
    selType = OFF_NONE;
    if (gated[BIT_OV]) begin
      selBit[BIT_OV] = 1'b1;
      selType = resp_q[RESP_OV_EMERG] ? OFF_EMERG : OFF_CRIT;
    end else if (gated[BIT_OC]) begin
      selBit[BIT_OC] = 1'b1;
      selType = OFF_CRIT;
    end else if (gated[BIT_TR]) begin
      selBit[BIT_TR] = 1'b1;
      selType = OFF_CRIT;
    end else if (gated[BIT_OT]) begin
      selBit[BIT_OT] = 1'b1;
      selType = resp_q[RESP_OT_CRIT] ? OFF_CRIT : OFF_SEQ;
    end else if (gated[BIT_UV]) begin
      selBit[BIT_UV] = 1'b1;
      selType = resp_q[RESP_UV_CRIT] ? OFF_CRIT : OFF_SEQ;
    end
  end
  assign anyFault = (selBit != 8'h00); // warning excluded
  assign selProp = |(selBit & prop_q);
  // configuration registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prop_q <= PROP_RST;
      resp_q <= RESP_RST;
      latch_q <= LATCH_RST;
    end else if (regReq.wr) begin
      case (regReq.addr)
        ADDR_PROP: prop_q <= regReq.wdata & PROP_MASK;
        ADDR_RESP: resp_q <= regReq.wdata & 8'h07;
        ADDR_LATCH: latch_q <= regReq.wdata & PROP_MASK;
        default: begin
        end
      endcase
    end
  end
  // sticky status, set beats write-one clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stat_q <= 8'h00;
    end else begin
      if (regReq.wr && regReq.addr == ADDR_STAT) begin
        stat_q <= (stat_q & ~regReq.wdata) | gated;
      end else begin
        stat_q <= stat_q | gated;
      end
    end
  end
  // read data one cycle after strobe
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_q <= 8'h00;
    end else if (regReq.rd) begin
      case (regReq.addr)
        ADDR_PROP: rdata_q <= prop_q;
        ADDR_STAT: rdata_q <= ~stat_q & 8'hbe; // active reads 0
        ADDR_RESP: rdata_q <= resp_q;
        ADDR_LATCH: rdata_q <= latch_q;
        default: rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end
  // leave off state when allowed
  always_comb begin
    releaseReq = 1'b0;
    case (state_q)
      ST_OFF: releaseReq = (retry_q == RETRY_CYCLES - 1);
      ST_HOLD: releaseReq = !(|(stat_q & faultSrc_q));
      ST_PEER: releaseReq = lineRise;
      default: releaseReq = 1'b0;
    endcase
  end
  // turn-off state machine
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= ST_RUN;
      offType_q <= OFF_NONE;
      lowSide_q <= 1'b0;
      faultSrc_q <= 8'h00;
    end else begin
      case (state_q)
        ST_RUN: begin
          if (anyFault) begin
            state_q <= ST_OFF;
            offType_q <= selType;
            lowSide_q <= selBit[BIT_OV];
            faultSrc_q <= selBit;
          end else if (decValid) begin
            state_q <= ST_PEER;
            offType_q <= decKind;
            lowSide_q <= (decKind == OFF_EMERG);
          end
        end
        ST_OFF: begin
          if (|(faultSrc_q & latch_q)) begin
            state_q <= ST_HOLD;
          end else if (releaseReq) begin
            state_q <= ST_RUN;
            offType_q <= OFF_NONE;
            lowSide_q <= 1'b0;
          end
        end
        ST_HOLD, ST_PEER: begin
          if (releaseReq) begin
            state_q <= ST_RUN;
            offType_q <= OFF_NONE;
            lowSide_q <= 1'b0;
          end
        end
        default: state_q <= ST_RUN;
      endcase
    end
  end
  // hiccup timer from fault entry, delay-independent
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      retry_q <= 32'h0;
    end else if (state_q == ST_OFF && !releaseReq) begin
      retry_q <= retry_q + 32'h1;
    end else begin
      retry_q <= 32'h0;
    end
  end
  // one-cycle restart request
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      restart_q <= 1'b0;
    end else begin
      restart_q <= (state_q != ST_RUN) && releaseReq;
    end
  end
  // request to send own kind
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pending_q <= 1'b0;
      drvType_q <= OFF_NONE;
    end else if (state_q == ST_RUN && anyFault && selProp) begin
      pending_q <= 1'b1;
      drvType_q <= selType;
    end else if (syncFall && !sendActive) begin
      pending_q <= 1'b0;
    end
  end
  // drive line only at sync falling edges
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lineLow_q <= 1'b0;
      step_q <= 3'h0;
    end else if (syncFall) begin
      if (pending_q && !sendActive) begin
        lineLow_q <= 1'b1;
        step_q <= 3'h1;
      end else if (step_q != 3'h0) begin
        lineLow_q <= patLow(step_q, drvType_q);
        step_q <= (step_q == ENC_LAST) ? 3'h0 : step_q + 3'h1;
      end else if (state_q == ST_RUN && !pending_q) begin
        lineLow_q <= 1'b0;
      end
    end
  end
  assign okLineOut = 1'b0;
  assign okLineOe = lineLow_q;
  assign convEnable = (state_q == ST_RUN);
  assign offType = offType_q;
  assign lowSideOn = lowSide_q;
  assign restartPulse = restart_q;
  assign regRdata = rdata_q;
  // an own fault announced on the line
  sequence sendBegins;
    $rose(okLineOe);
  endsequence
  sequence firstStepLow;
    okLineOe [*4];
  endsequence
  line_edge_a: assert property (@(posedge clk) disable iff (sys_rst)
    $changed(okLineOe) |-> $past(syncFall))
    else $error("fault line moved off a sync fall");
  prop_off_a: assert property (@(posedge clk) disable iff (sys_rst)
    state_q == ST_RUN && anyFault && !selProp |=> !pending_q)
    else $error("disabled fault was propagated");
  prop_on_a: assert property (@(posedge clk) disable iff (sys_rst)
    state_q == ST_RUN && anyFault && selProp |=> pending_q && !convEnable)
    else $error("enabled fault not propagated");
  uv_seq_a: assert property (@(posedge clk) disable iff (sys_rst)
    state_q == ST_RUN && selBit[BIT_UV] && !resp_q[RESP_UV_CRIT]
    |=> offType == OFF_SEQ)
    else $error("undervoltage not sequenced");
  retry_time_a: assert property (@(posedge clk) disable iff (sys_rst)
    restartPulse && $past(state_q) == ST_OFF
    |-> $past(retry_q) == RETRY_CYCLES - 1)
    else $error("hiccup interval wrong");
  peer_follow_a: assert property (@(posedge clk) disable iff (sys_rst)
    state_q == ST_RUN && !anyFault && decValid
    |=> state_q == ST_PEER && offType == $past(decKind))
    else $error("peer kind not followed");
  prop_read_a: assert property (@(posedge clk) disable iff (sys_rst)
    regReq.rd && regReq.addr == ADDR_PROP |=> regRdata[7:6] == 2'b00)
    else $error("unimplemented enable bits read set");
  warn_only_a: assert property (@(posedge clk) disable iff (sys_rst)
    state_q == ST_RUN && gated == 8'h80 && !decValid
    |=> convEnable && stat_q[BIT_TW])
    else $error("warning turned output off");
  send_start_a: assert property (@(posedge clk) disable iff (sys_rst)
    sendBegins |-> firstStepLow)
    else $error("fault line pattern too short");
  // a latched fault never hiccups on its own
  hold_stay_a: assert property (@(posedge clk) disable iff (sys_rst)
    state_q == ST_HOLD && (|(stat_q & faultSrc_q)) |=> !restartPulse && !convEnable)
    else $error("latched fault restarted early");
  // overtemperature turns off with the low side off
  ot_lowside_a: assert property (@(posedge clk) disable iff (sys_rst)
    state_q == ST_RUN && selBit[BIT_OT] |=> !lowSideOn && !convEnable)
    else $error("overtemperature turn-off wrong");
  // a non-emergency peer kind gives a regular turn-off
  peer_reg_a: assert property (@(posedge clk) disable iff (sys_rst)
    state_q == ST_RUN && !anyFault && decValid && decKind != OFF_EMERG
    |=> !lowSideOn && !convEnable)
    else $error("peer turn-off not regular");
endmodule
`default_nettype wire

// ==== tb/fpl_mgr_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// sync source of the manager plus one peer converter on the fault line
module fpl_mgr_model
  import fpl_pkg::*;
#(
  parameter time HALF = 32
) (
  input wire fpl_off_t sendKind,
  output logic syncClk,
  output logic peerOe
);
  logic [2:0] step; // position in the pattern
  // sync runs free, 64 ns period in the bench
  initial syncClk = 1'b1;
  always #(HALF) syncClk = ~syncClk;
  initial begin
    step = 3'h0;
    peerOe = 1'b0;
  end
  // pattern steps and release only at sync falls
  always @(negedge syncClk) begin
    if (sendKind == OFF_NONE) begin
      step <= 3'h0;
      peerOe <= 1'b0;
    end else begin
      // kind is sent as given, never altered
      case (step)
        3'h1: peerOe <= (sendKind == OFF_SEQ);
        3'h3: peerOe <= (sendKind != OFF_EMERG);
        default: peerOe <= 1'b1;
      endcase
      if (step < 3'h4) step <= step + 3'h1;
    end
  end
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
// bench top: register port, own faults, peer patterns
module tb_top;
  import fpl_pkg::*;
  localparam int RT = 2000; // shortened retry interval
  logic clk, sysRst, rdLast;
  fpl_reg_req_t regReq;
  logic [7:0] regRdata, v;
  fpl_faults_t faultIn;
  logic okLine, okLineOut, okLineOe, convEnable, lowSideOn, restartPulse;
  logic syncClk, peerOe, seen;
  logic vinPresent, rampPhase; // detector qualifiers
  logic [3:0] pat;
  fpl_off_t offType, sendKind;
  integer seed, errors, n_checks, i, j;
  time t0;
  logic [7:0] expQ[$]; // expected read data
  // own-fault table: fault, response, kind, pattern, low side
  logic [5:0] tF[6] = '{6'h02, 6'h02, 6'h08, 6'h01, 6'h04, 6'h10};
  logic [7:0] tR[6] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h00, 8'h00};
  fpl_off_t tK[6] = '{OFF_SEQ, OFF_CRIT, OFF_CRIT, OFF_EMERG, OFF_CRIT, OFF_CRIT};
  logic [3:0] tP[6] = '{4'h0, 4'h2, 4'h2, 4'ha, 4'h2, 4'h2};
  logic tL[6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
  // open-drain line with pull-up
  assign okLine = ~(okLineOe | peerOe);
  fpl_fault_prop #(.RETRY_CYCLES(RT)) u_fpl_fault_prop (
    .clk(clk), .sys_rst(sysRst), .regReq(regReq), .regRdata(regRdata),
    .faultIn(faultIn), .vinPresent(vinPresent), .rampPhase(rampPhase), .steadyState(1'b1),
    .aboveBias(1'b1), .syncClockLine(syncClk), .okLineIn(okLine),
    .okLineOut(okLineOut), .okLineOe(okLineOe), .convEnable(convEnable),
    .offType(offType), .lowSideOn(lowSideOn), .restartPulse(restartPulse)
  );
  fpl_mgr_model u_fpl_mgr_model (.sendKind(sendKind), .syncClk(syncClk), .peerOe(peerOe));
  always #2 clk = ~clk;
  // generic compare
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    regReq.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    regReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    expQ.push_back(e);
    @(posedge clk);
    regReq.rd <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  always @(posedge clk) rdLast <= regReq.rd;
  always @(negedge clk) begin
    if (rdLast === 1'b1 && expQ.size() > 0) chk(regRdata, expQ.pop_front());
  end
  function automatic logic cur(input int w);
    case (w)
      0: return okLineOe;
      1: return convEnable;
      default: return restartPulse;
    endcase
  endfunction
  // bounded wait; running out counts as a mismatch
  task automatic waitv(input int w, input logic val, input int lim);
    int k;
    k = 0;
    while (cur(w) !== val && k < lim) begin
      @(negedge clk);
      k++;
    end
    chk(8'(cur(w)), 8'(val));
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // watchdog
  initial begin
    #160000;
    errors++;
    $display("watchdog expired at %0t", $time);
    end_sim();
  end
  // main sequence
  initial begin
    clk = 0; sysRst = 1; regReq = '0; faultIn = '0; sendKind = OFF_NONE; rdLast = 0;
    errors = 0; n_checks = 0; seed = 32'h8202;
    vinPresent = 1'b1;
    rampPhase = 1'b1;
    repeat (12) @(posedge clk);
    sysRst <= 1'b0;
    rd(ADDR_PROP, PROP_RST);
    rd(ADDR_RESP, RESP_RST);
    rd(ADDR_LATCH, LATCH_RST);
    rd(ADDR_STAT, 8'hbe);
    rd(4'h9, 8'h00);
    for (i = 0; i < 4; i++) begin
      v = 8'($random(seed));
      wr(ADDR_PROP, v);
      rd(ADDR_PROP, v & PROP_MASK);
    end
    wr(ADDR_PROP, PROP_RST);
    $display("test registers done");
    // warning sets status only
    @(posedge clk) faultIn.tempWarn <= 1'b1;
    rd(ADDR_STAT, 8'h3e);
    @(posedge clk) faultIn.tempWarn <= 1'b0;
    rd(ADDR_STAT, 8'h3e);
    wr(ADDR_STAT, 8'h80);
    rd(ADDR_STAT, 8'hbe);
    chk(8'(convEnable), 8'h01);
    // without input voltage the warning is not watched
    @(posedge clk) begin
      vinPresent <= 1'b0;
      faultIn.tempWarn <= 1'b1;
    end
    rd(ADDR_STAT, 8'hbe);
    @(posedge clk) begin
      vinPresent <= 1'b1;
      faultIn.tempWarn <= 1'b0;
    end
    $display("test warning done");
    // own faults, each sent on the line then retried
    for (i = 0; i < 6; i++) begin
      wr(ADDR_RESP, tR[i]);
      @(posedge clk) faultIn <= fpl_faults_t'(tF[i]);
      @(posedge clk) faultIn <= '0;
      @(negedge clk);
      t0 = $time;
      chk(8'(convEnable), 8'h00);
      chk(8'(offType), 8'(tK[i]));
      waitv(0, 1'b1, 40);
      chk(8'(okLineOut), 8'h00);
      chk(8'(lowSideOn), 8'(tL[i]));
      for (j = 0; j < 4; j++) begin
        @(posedge syncClk);
        pat[j] = okLine;
      end
      chk(8'(pat), 8'(tP[i]));
      waitv(2, 1'b1, RT + 100);
      chk(8'(($time - t0) / 4 > RT - 10 && ($time - t0) / 4 < RT + 10), 8'h01);
      chk(8'(convEnable), 8'h01);
      waitv(0, 1'b0, 40);
      $display("test own fault %0d done", i);
    end
    // propagation disabled: local off, line left alone
    wr(ADDR_RESP, 8'h00);
    wr(ADDR_PROP, 8'h3b);
    @(posedge clk) faultIn.underVolt <= 1'b1;
    @(posedge clk) faultIn <= '0;
    seen = 1'b0;
    repeat (300) @(negedge clk) seen = seen | okLineOe;
    chk(8'(seen), 8'h00);
    chk(8'(convEnable), 8'h00);
    waitv(2, 1'b1, RT + 100);
    wr(ADDR_PROP, PROP_RST);
    $display("test no propagation done");
    // latching fault holds off until its status bit is cleared
    wr(ADDR_STAT, 8'hbe);
    wr(ADDR_LATCH, 8'h08);
    @(posedge clk) faultIn.overCurrent <= 1'b1;
    @(posedge clk) faultIn <= '0;
    seen = 1'b0;
    repeat (RT + 50) @(negedge clk) seen = seen | convEnable | restartPulse;
    chk(8'(seen), 8'h00);
    rd(ADDR_STAT, 8'hb6);
    wr(ADDR_STAT, 8'h08);
    waitv(2, 1'b1, 20);
    wr(ADDR_LATCH, LATCH_RST);
    waitv(0, 1'b0, 40);
    $display("test latching fault done");
    // peer patterns of every kind
    for (i = 1; i < 4; i++) begin
      @(posedge clk) sendKind <= fpl_off_t'(i);
      waitv(1, 1'b0, 200);
      repeat (6) @(posedge syncClk);
      @(negedge clk);
      chk(8'(offType), 8'(i));
      chk(8'(okLineOe), 8'h00);
      chk(8'(lowSideOn), 8'(i == 3));
      @(posedge clk) sendKind <= OFF_NONE;
      waitv(1, 1'b1, 400);
      $display("test peer kind %0d done", i);
    end
    repeat (4) @(posedge clk);
    end_sim();
  end
endmodule
`default_nettype wire
